// [rtl/adc_sweep_pga_control.sv]
/*
 Sweep and manual control of a 12-bit converter and its gain amplifier, with the
 result FIFO and the per-channel result buffers.
 Assumes the analog core raises conv_done with stable data while conv_start is high,
 and lowers it after conv_start falls; both arrive from outside the clock domain.
*/
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Result FIFO
// ---------------------------------------------------------------
module sweep_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   // A spare pointer bit tells a full FIFO from an empty one.
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_state_t;
   fifo_state_t f_q;
   fifo_state_t f_d;

   // Pointer arithmetic relies on wrap-around, so the depth must be a power of two.
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_check
      $error("sweep_fifo: DEPTH must be a power of two of at least 2");
   end

   // Full and empty come straight from the pointers.
   assign in_ready = (f_q.wr - f_q.rd) != (AW + 1)'(DEPTH);
   assign out_valid = f_q.wr != f_q.rd;

   assign out_data = f_q.mem[f_q.rd[AW-1:0]];

   // Push and pop may happen in the same cycle.
   always_comb begin
      f_d = f_q;
      if (in_valid && in_ready) begin
         f_d.mem[f_q.wr[AW-1:0]] = in_data;
         f_d.wr = f_q.wr + 1'b1;
      end
      if (out_valid && out_ready) begin
         f_d.rd = f_q.rd + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end
endmodule : sweep_fifo

// ---------------------------------------------------------------
// Controller
// ---------------------------------------------------------------
module adc_sweep_pga_control #(
   parameter int NUM_CH = 8,
   parameter int BUF_BYTES = 128,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [10:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic conv_sample,
   output logic conv_start,
   output adc_sweep_pkg::conv_sel_t conv_sel,
   input wire logic conv_done,
   input wire logic [11:0] conv_result,
   output adc_sweep_pkg::amp_ctrl_t amp_ctrl
);
   localparam int SLOTS = BUF_BYTES / 2;

   localparam int MEM_WORDS = NUM_CH * SLOTS;

   if (NUM_CH != 8 || BUF_BYTES != 128) begin : g_check
      $error("adc_sweep_pga_control: map is laid out for 8 channels of 128 bytes");
   end

   typedef struct packed {
      adc_sweep_pkg::conv_state_t st;
      logic [31:0] ctrl;
      logic [3:0][31:0] cfg;
      logic [7:0] full;
      logic [7:0] once;
      logic [7:0][5:0] wptr;
      logic [2:0] scan;
      logic [2:0] ch;
      logic [7:0] pace;
      logic [2:0] tdiv;
      logic [5:0] tcnt;
      logic done_s1;
      logic done_s2;
      logic [11:0] res_s1;
      logic [11:0] res_s2;
      logic [31:0] rdata;
   } ctl_state_t;

   ctl_state_t q;
   ctl_state_t d;

   logic [11:0] mem [MEM_WORDS];
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [14:0] fifo_out_data;

   logic push;
   logic mem_rd;
   logic drain;

   logic manual;
   logic [15:0] field;
   logic [15:0] scan_field;
   logic scan_ok;

   logic [7:0] pace_cyc;
   logic [5:0] sample_ticks;
   logic [1:0] se_mode;

   // ---------------------------------------------------------------
   // Decode of the live configuration
   // ---------------------------------------------------------------
   assign manual = q.ctrl[adc_sweep_pkg::CTRL_MANUAL];
   assign se_mode = q.ctrl[adc_sweep_pkg::CTRL_SE_LSB +: 2];

   // Channel pairs share one register: even index in the low half.
   assign field = q.cfg[q.ch[2:1]][q.ch[0]*16 +: 16];
   assign scan_field = q.cfg[q.scan[2:1]][q.scan[0]*16 +: 16];
   assign scan_ok = scan_field[adc_sweep_pkg::CFG_EN] && !q.once[q.scan];

   // Pace between sample window starts.
   always_comb begin
      case (q.ctrl[adc_sweep_pkg::CTRL_RATE_LSB +: 2])
         adc_sweep_pkg::RATE_80K: pace_cyc = 8'(adc_sweep_pkg::PACE_SLOW_CYC);
         adc_sweep_pkg::RATE_160K: pace_cyc = 8'(adc_sweep_pkg::PACE_MID_CYC);
         default: pace_cyc = 8'(adc_sweep_pkg::PACE_FAST_CYC);
      endcase
   end

   // Sampling window in base periods; manual mode uses the shortest setting.
   always_comb begin
      logic [5:0] steps;
      steps = manual ? 6'h00 : 6'(field[adc_sweep_pkg::CFG_ST_LSB +: 4]);
      sample_ticks = 6'(steps * adc_sweep_pkg::ST_STEP);
      if (q.ctrl[adc_sweep_pkg::CTRL_MAX256]) begin
         sample_ticks = sample_ticks + 6'(adc_sweep_pkg::ST_OFS_256);
      end else begin
         sample_ticks = sample_ticks + 6'(adc_sweep_pkg::ST_OFS_320);
      end
   end

   // ---------------------------------------------------------------
   // Outputs towards the analog core
   // ---------------------------------------------------------------
   assign conv_sample = q.st == adc_sweep_pkg::S_SAMPLE;
   assign conv_start = q.st == adc_sweep_pkg::S_CONVERT;
   assign conv_sel.chan = q.ch;

   // Manual mode takes the pair's mode from the control register, sweep from the field.
   assign conv_sel.diff = manual ? (se_mode == adc_sweep_pkg::SE_DIFF)
                                 : field[adc_sweep_pkg::CFG_DIFF];
   assign conv_sel.neg = manual ? (se_mode == adc_sweep_pkg::SE_NEG)
                                : (!field[adc_sweep_pkg::CFG_DIFF] && q.ch[0]);
   assign amp_ctrl.amp_single_ended_force = q.ctrl[adc_sweep_pkg::CTRL_AMP_SE];

   // Stage one is 5 or 15 V/V, stage two trims in 3 dB steps up to 42 dB total.
   assign amp_ctrl.first_stage_gain_sel = q.ctrl[adc_sweep_pkg::CTRL_G1];
   assign amp_ctrl.second_stage_gain_sel = q.ctrl[adc_sweep_pkg::CTRL_G2_LSB +: 3];

   assign reg_rdata = q.rdata;

   // ---------------------------------------------------------------
   // Result path
   // ---------------------------------------------------------------
   // A result is taken only when the FIFO has room; otherwise the request stays up,
   // so a slow drain stalls the conversion sequence instead of dropping data.
   assign push = (q.st == adc_sweep_pkg::S_CONVERT) && q.done_s2 && fifo_in_ready;

   // The buffer has one port; a software read wins and the drain waits for as long as the read is up.
   assign mem_rd = reg_rd && reg_addr[adc_sweep_pkg::MEM_SEL_BIT];
   assign drain = fifo_out_valid && !mem_rd;

   sweep_fifo #(
      .WIDTH(15),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset_n(reset_n),
      .in_valid(push),
      .in_data({q.ch, q.res_s2}),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(!mem_rd)
   );

   // Buffer storage; each channel owns a contiguous slot range.
   always_ff @(posedge clock) begin
      if (drain) begin
         mem[{fifo_out_data[14:12], q.wptr[fifo_out_data[14:12]]}] <= fifo_out_data[11:0];
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [2:0] dch;
      dch = fifo_out_data[14:12];
      d = q;

      // The converter signals cross in through two flops; data is stable before done.
      d.done_s1 = conv_done;
      d.done_s2 = q.done_s1;
      d.res_s1 = conv_result;
      d.res_s2 = q.res_s1;

      if (q.pace != 8'hff) begin
         d.pace = q.pace + 8'h01;
      end
      d.tdiv = (q.tdiv == 3'(adc_sweep_pkg::BASE_CYC - 1)) ? 3'h0 : q.tdiv + 3'h1;

      // Buffer write pointers wrap; the flag marks a completed fill of 64 results.
      if (drain) begin
         d.wptr[dch] = q.wptr[dch] + 6'h01;
      end

      // Register writes; full flags clear on a written one.
      d.rdata = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            adc_sweep_pkg::CTRL_OFS: d.ctrl = reg_wdata & adc_sweep_pkg::CTRL_MASK;
            adc_sweep_pkg::STATUS_OFS: d.full = q.full & ~reg_wdata[7:0];
            adc_sweep_pkg::CFG_TEMP_AMP_OFS: d.cfg[0] = reg_wdata;
            adc_sweep_pkg::CFG_A_OFS: d.cfg[1] = reg_wdata;
            adc_sweep_pkg::CFG_B_OFS: d.cfg[2] = reg_wdata;
            adc_sweep_pkg::CFG_C_OFS: d.cfg[3] = reg_wdata;
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      // Set after clear, so a fill in the clearing cycle is kept.
      if (drain && q.wptr[dch] == 6'(SLOTS - 1)) begin
         d.full[dch] = 1'b1;
      end

      // Register reads answer one cycle later; unmapped addresses read zero.
      if (reg_rd) begin
         if (mem_rd) begin
            d.rdata = {4'h0, mem[{reg_addr[9:2], 1'b1}], 4'h0, mem[{reg_addr[9:2], 1'b0}]};
         end else begin
            case (reg_addr)
               adc_sweep_pkg::CTRL_OFS: d.rdata = q.ctrl;
               adc_sweep_pkg::STATUS_OFS: d.rdata = {11'h000, q.st, q.once, q.full};
               adc_sweep_pkg::CFG_TEMP_AMP_OFS: d.rdata = q.cfg[0];
               adc_sweep_pkg::CFG_A_OFS: d.rdata = q.cfg[1];
               adc_sweep_pkg::CFG_B_OFS: d.rdata = q.cfg[2];
               adc_sweep_pkg::CFG_C_OFS: d.rdata = q.cfg[3];
               default: d.rdata = 32'h0000_0000;
            endcase
         end
      end

      // One-shot history only lives while a sweep is running.
      if (manual || !q.ctrl[adc_sweep_pkg::CTRL_ENABLE]) begin
         d.once = 8'h00;
      end

      // Conversion sequencer.
      case (q.st)
         adc_sweep_pkg::S_IDLE: begin
            if (q.ctrl[adc_sweep_pkg::CTRL_ENABLE]) begin
               if (manual) begin
                  d.ch = q.ctrl[adc_sweep_pkg::CTRL_CHAN_LSB +: 3];
                  d.st = adc_sweep_pkg::S_PACE;
               end else if (scan_ok) begin
                  d.ch = q.scan;
                  d.st = adc_sweep_pkg::S_PACE;
               end else begin
                  d.scan = q.scan + 3'h1;
               end
            end
         end
         adc_sweep_pkg::S_PACE: begin
            if (q.pace >= pace_cyc - 8'h01) begin
               d.pace = 8'h00;
               d.tcnt = 6'h00;
               // A whole base period passes before the first tick.
               d.tdiv = 3'h0;
               d.st = adc_sweep_pkg::S_SAMPLE;
            end
         end
         adc_sweep_pkg::S_SAMPLE: begin
            if (q.tdiv == 3'(adc_sweep_pkg::BASE_CYC - 1)) begin
               d.tcnt = q.tcnt + 6'h01;
               if (q.tcnt + 6'h01 >= sample_ticks) begin
                  d.st = adc_sweep_pkg::S_CONVERT;
               end
            end
         end
         adc_sweep_pkg::S_CONVERT: begin
            if (push) begin
               if (!manual && field[adc_sweep_pkg::CFG_ONESHOT]) begin
                  d.once[q.ch] = 1'b1;
               end
               if (!manual) begin
                  d.scan = q.ch + 3'h1;
               end
               d.st = adc_sweep_pkg::S_RELEASE;
            end
         end
         adc_sweep_pkg::S_RELEASE: begin
            if (!q.done_s2) begin
               d.st = adc_sweep_pkg::S_IDLE;
            end
         end
         default: d.st = adc_sweep_pkg::S_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.st <= adc_sweep_pkg::S_IDLE;
         q.ctrl <= adc_sweep_pkg::CTRL_RESET;
         q.cfg <= {4{adc_sweep_pkg::CFG_RESET}};
      end else begin
         q <= d;
      end
   end
endmodule : adc_sweep_pga_control
`default_nettype wire

// [shared/adc_sweep_pkg.sv]
/*
 Constants, register map and carrier types of the converter sweep controller.
 Assumes a single 10 MHz clock and a word-aligned plain register port.
*/
`default_nettype none
package adc_sweep_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int RATE_SLOW_SPS = 80_000;
   localparam int RATE_MID_SPS = 160_000;
   localparam int RATE_FAST_SPS = 320_000;
   localparam int BASE_HZ = 1_280_000;
   // Pace cycles round down, so a conversion period can be slightly shorter than asked;
   // the base period rounds up as a least time.
   localparam int PACE_SLOW_CYC = CLK_HZ / RATE_SLOW_SPS;
   localparam int PACE_MID_CYC = CLK_HZ / RATE_MID_SPS;
   localparam int PACE_FAST_CYC = CLK_HZ / RATE_FAST_SPS;
   localparam int BASE_CYC = (CLK_HZ + BASE_HZ - 1) / BASE_HZ;
   localparam int ST_OFS_320 = 2;
   localparam int ST_OFS_256 = 3;
   localparam int ST_STEP = 4;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [10:0] CTRL_OFS = 11'h000;
   localparam logic [10:0] STATUS_OFS = 11'h004;
   localparam logic [10:0] CFG_TEMP_AMP_OFS = 11'h06c;
   localparam logic [10:0] CFG_A_OFS = 11'h070;
   localparam logic [10:0] CFG_B_OFS = 11'h074;
   localparam logic [10:0] CFG_C_OFS = 11'h078;
   localparam int MEM_SEL_BIT = 10;
   // Control register fields.
   localparam int CTRL_MANUAL = 0;
   localparam int CTRL_ENABLE = 1;
   localparam int CTRL_RATE_LSB = 2;
   localparam int CTRL_CHAN_LSB = 4;
   localparam int CTRL_SE_LSB = 8;
   localparam int CTRL_AMP_SE = 10;
   localparam int CTRL_G1 = 11;
   localparam int CTRL_G2_LSB = 12;
   localparam int CTRL_MAX256 = 15;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [31:0] CTRL_MASK = 32'h0000_ff7f;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // Per-channel configuration field, one per 16-bit half.
   localparam int CFG_ST_LSB = 0;
   localparam int CFG_EN = 4;
   localparam int CFG_DIFF = 5;
   localparam int CFG_ONESHOT = 6;
   // Rate and single-ended codes.
   localparam logic [1:0] RATE_80K = 2'h0;
   localparam logic [1:0] RATE_160K = 2'h1;
   localparam logic [1:0] SE_DIFF = 2'h0;
   localparam logic [1:0] SE_NEG = 2'h2;
   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] chan;
      logic diff;
      logic neg;
   } conv_sel_t;
   typedef struct packed {
      logic amp_single_ended_force;
      logic first_stage_gain_sel;
      logic [2:0] second_stage_gain_sel;
   } amp_ctrl_t;
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_PACE = 5'h02,
      S_SAMPLE = 5'h04,
      S_CONVERT = 5'h08,
      S_RELEASE = 5'h10
   } conv_state_t;
endpackage : adc_sweep_pkg
`default_nettype wire

// [sim/adc_sweep_asserts.sv]
/*
 Port checker of the converter sweep controller.
 Assumes it is bound to the controller and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_sweep_asserts (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [10:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic conv_sample,
   input wire logic conv_start,
   input wire adc_sweep_pkg::conv_sel_t conv_sel,
   input wire logic conv_done,
   input wire logic [11:0] conv_result,
   input wire adc_sweep_pkg::amp_ctrl_t amp_ctrl
);
   localparam int GAP_MIN = adc_sweep_pkg::PACE_FAST_CYC - 1;
   localparam int WIN_MAX = 63 * adc_sweep_pkg::BASE_CYC;
   logic [7:0] gap_q;
   logic [9:0] win_q;
   // ---------------------------------------------------------------
   // Helper counters
   // ---------------------------------------------------------------
   // The gap counter saturates so that a long idle spell cannot wrap into a false failure.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gap_q <= 8'hff;
         win_q <= 10'h000;
      end else begin
         gap_q <= $rose(conv_sample) ? 8'h01 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
         win_q <= conv_sample ? win_q + 10'h001 : 10'h000;
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   chk_amp_follow: assert property (
      reg_wr && reg_addr == adc_sweep_pkg::CTRL_OFS |=> amp_ctrl == {$past(reg_wdata[10]),
      $past(reg_wdata[11]), $past(reg_wdata[14:12])}) else $error("amplifier control wrong");
   chk_amp_hold: assert property (
      !(reg_wr && reg_addr == adc_sweep_pkg::CTRL_OFS) |=> $stable(amp_ctrl))
      else $error("amplifier control moved without write");
   chk_start_after_win: assert property ($rose(conv_start) |-> $past(conv_sample))
      else $error("conversion began without sample window");
   chk_sample_excl: assert property (!(conv_sample && conv_start))
      else $error("sample and convert overlap");
   chk_start_held: assert property (conv_start && !conv_done |=> conv_start)
      else $error("conversion request dropped early");
   chk_start_release: assert property ($fell(conv_start) |-> $past(conv_done, 2))
      else $error("request dropped before synced done");
   chk_new_start_low: assert property ($rose(conv_start) |-> !conv_done)
      else $error("new request while done still high");
   chk_sel_steady: assert property (conv_start && $past(conv_start) |-> $stable(conv_sel))
      else $error("selection changed during conversion");
   chk_pace_min: assert property ($rose(conv_sample) |-> gap_q >= GAP_MIN)
      else $error("samples closer than fastest rate");
   chk_win_max: assert property (conv_sample |-> win_q < WIN_MAX)
      else $error("sample window too long");
   cover property ($rose(conv_start));
   cover property ($fell(conv_start));
   cover property (conv_start && conv_done [*8]);
endmodule : adc_sweep_asserts
`default_nettype wire

// [sim/adc_core_model.sv]
/*
 Behavioural model of the analog converter core and its input selector.
 Assumes the controller holds conv_start until it has seen conv_done.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic conv_start,
   input wire logic slow,
   input wire adc_sweep_pkg::conv_sel_t conv_sel,
   output logic conv_done,
   output logic [11:0] conv_result
);
   logic [4:0] wait_q;
   logic [6:0] seq_q;
   // Result tags the selection and a sequence so that misfiled data shows up.
   // Released data is inverted so a stale value is never mistaken for a fresh one.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         conv_done <= 1'b0;
         conv_result <= 12'h000;
         wait_q <= 5'h01;
         seq_q <= 7'h00;
      end else if (!conv_start) begin
         if (conv_done) begin
            conv_result <= ~conv_result;
         end
         conv_done <= 1'b0;
         wait_q <= slow ? 5'($urandom_range(20, 3)) : 5'h01;
      end else if (wait_q != 5'h00) begin
         wait_q <= wait_q - 5'h01;
      end else if (!conv_done) begin
         conv_done <= 1'b1;
         conv_result <= {conv_sel, seq_q};
         seq_q <= seq_q + 7'h01;
      end
   end
endmodule : adc_core_model
`default_nettype wire

// [sim/adc_sweep_pga_control_tb.sv]
/*
 Self-checking bench of the converter sweep controller.
 Assumes the controller, its checker and the converter core model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_sweep_pga_control_tb;
   logic clock, reset_n, reg_wr, reg_rd, slow, done_q, samp_q, start_q, manual, max256;
   logic [10:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_q, d;
   logic conv_sample, conv_start, conv_done;
   logic [11:0] conv_result;
   adc_sweep_pkg::conv_sel_t conv_sel;
   adc_sweep_pkg::amp_ctrl_t amp_ctrl;
   logic [11:0] exp_buf [8][64];
   logic [15:0] cfg [8];
   logic [7:0] full_exp;
   logic [2:0] man_ch, c;
   logic [1:0] se;
   int nconv [8];
   int mismatches, compares, cycles, win_n, stall_n, stall_max, i, m, base;
   adc_sweep_pga_control u_adc_sweep_pga_control (.clock(clock), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .conv_sample(conv_sample), .conv_start(conv_start),
      .conv_sel(conv_sel), .conv_done(conv_done), .conv_result(conv_result),
      .amp_ctrl(amp_ctrl));
   adc_core_model u_adc_core_model (.clock(clock), .reset_n(reset_n), .conv_start(conv_start),
      .slow(slow), .conv_sel(conv_sel), .conv_done(conv_done), .conv_result(conv_result));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   task automatic wr(input logic [10:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data is taken half a cycle after the strobe edge, where it has settled.
   task automatic rd(input logic [10:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      rd_q = reg_rdata;
   endtask : rd
   task automatic set_cfg(input int k, input logic [15:0] v);
      cfg[k] = v;
      wr(adc_sweep_pkg::CFG_TEMP_AMP_OFS + 11'(k / 2 * 4), {cfg[k | 1], cfg[k & 6]});
   endtask : set_cfg
   task automatic wait_idle;
      for (int n = 0; n < 400; n++) begin
         rd(adc_sweep_pkg::STATUS_OFS);
         if (rd_q[20:16] === 5'h01) break;
      end
      check("idle", 32'h1, 32'(rd_q[20:16]));
   endtask : wait_idle
   task automatic check_buf(input int k);
      wr(11'h400 + 11'(k * 128), 32'hffff_ffff);
      for (int j = 0; 2 * j + 1 < nconv[k] && j < 32; j++) begin
         rd(11'h400 + 11'(k * 128 + j * 4));
         check("buf", {4'h0, exp_buf[k][2 * j + 1], 4'h0, exp_buf[k][2 * j]}, rd_q);
      end
   endtask : check_buf
   function automatic logic [31:0] win_len(input logic [2:0] k);
      int st;
      st = manual ? 0 : int'(cfg[k][3:0]);
      return 32'((st * 4 + (max256 ? 3 : 2)) * adc_sweep_pkg::BASE_CYC);
   endfunction : win_len
   function automatic logic [31:0] exp_sel(input logic [2:0] k);
      if (manual) return {27'h0, man_ch, se == 2'h0, se == 2'h2};
      return {27'h0, k, cfg[k][5], !cfg[k][5] && k[0]};
   endfunction : exp_sel
   // ---------------------------------------------------------------
   // Monitor of the converter side
   // ---------------------------------------------------------------
   // A result counts when the request falls with done high, which is when it is kept.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         final_report();
      end
      done_q <= conv_done;
      samp_q <= conv_sample;
      start_q <= conv_start;
      win_n <= conv_sample ? win_n + 1 : 0;
      stall_n <= (conv_start && conv_done) ? stall_n + 1 : 0;
      if (stall_n > stall_max) stall_max = stall_n;
      if (samp_q && !conv_sample) check("window", win_len(conv_sel.chan), win_n);
      if (start_q && !conv_start && conv_done) begin
         c = conv_sel.chan;
         check("sel", exp_sel(c), 32'(conv_sel));
         check("enabled", 1, manual || cfg[c][4]);
         exp_buf[c][nconv[c] % 64] = conv_result;
         if (nconv[c] % 64 == 63) full_exp[c] = 1'b1;
         nconv[c]++;
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      {reg_wr, reg_rd, slow, max256} = 4'h0;
      {reg_addr, reg_wdata, man_ch, se, full_exp} = '0;
      {mismatches, compares, cycles, win_n, stall_n, stall_max} = '0;
      manual = 1'b1;
      foreach (cfg[k]) cfg[k] = 16'h0000;
      foreach (nconv[k]) nconv[k] = 0;
      void'($urandom(32'h5c7bd4c4));
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      rd(adc_sweep_pkg::CTRL_OFS);
      check("ctrl", adc_sweep_pkg::CTRL_RESET, rd_q);
      check("amp", 32'h0, 32'(amp_ctrl));
      for (i = 0; i < 4; i++) begin
         rd(adc_sweep_pkg::CFG_TEMP_AMP_OFS + 11'(i * 4));
         check("cfg", adc_sweep_pkg::CFG_RESET, rd_q);
      end
      rd(11'h010);
      check("unmapped", 32'h0, rd_q);
      for (i = 0; i < 8; i++) begin
         d = ($urandom() & adc_sweep_pkg::CTRL_MASK & ~32'h2) | 32'h1;
         wr(adc_sweep_pkg::CTRL_OFS, d);
         rd(adc_sweep_pkg::CTRL_OFS);
         check("ctrl", d, rd_q);
         check("amp", {27'h0, d[10], d[11], d[14:12]}, 32'(amp_ctrl));
         set_cfg(i, 16'($urandom() & 32'h7f));
         rd(adc_sweep_pkg::CFG_TEMP_AMP_OFS + 11'(i / 2 * 4));
         check("cfg", {cfg[i | 1], cfg[i & 6]}, rd_q);
      end
      // Manual run at the fastest rate; a long read burst stalls the drain to fill the FIFO.
      max256 = 1'b0;
      man_ch = 3'($urandom_range(7, 0));
      se = 2'($urandom_range(2, 0));
      wr(adc_sweep_pkg::CTRL_OFS, {22'h0, se, 1'b0, man_ch, 4'hb});
      wait (nconv[man_ch] >= 4);
      @(posedge clock);
      reg_addr <= 11'h400;
      reg_rd <= 1'b1;
      repeat (900) @(posedge clock);
      reg_rd <= 1'b0;
      check("stall", 1, stall_max > 40);
      wait (nconv[man_ch] >= 70);
      wr(adc_sweep_pkg::CTRL_OFS, {22'h0, se, 1'b0, man_ch, 4'h9});
      wait_idle();
      check("full", 32'(full_exp), 32'(rd_q[7:0]));
      wr(adc_sweep_pkg::STATUS_OFS, 32'(full_exp));
      full_exp = 8'h00;
      rd(adc_sweep_pkg::STATUS_OFS);
      check("full clr", 32'h0, 32'(rd_q[7:0]));
      check_buf(man_ch);
      // Sweep passes, the second with slow core answers and the 256k timing.
      for (m = 0; m < 2; m++) begin
         max256 = m[0];
         slow = m[0];
         for (i = 0; i < 8; i++) set_cfg(i, 16'h0000);
         set_cfg(2, {9'h0, 3'b011, 4'($urandom_range(15, 0))});
         set_cfg(5, 16'h0050);
         set_cfg(7, 16'h0027);
         base = nconv[5];
         i = nconv[2];
         manual = 1'b0;
         wr(adc_sweep_pkg::CTRL_OFS, {16'h0, m[0], 11'h0, 4'ha});
         wait (nconv[2] >= i + 12);
         rd(adc_sweep_pkg::STATUS_OFS);
         check("oneshot", 32'h20, 32'(rd_q[15:8]));
         wr(adc_sweep_pkg::CTRL_OFS, 32'h8);
         wait_idle();
         check("oneshot n", base + 1, nconv[5]);
         check_buf(2);
         check_buf(5);
         manual = 1'b1;
      end
      final_report();
   end
endmodule : adc_sweep_pga_control_tb
bind adc_sweep_pga_control adc_sweep_asserts u_adc_sweep_asserts (.clock(clock),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_sample(conv_sample),
   .conv_start(conv_start), .conv_sel(conv_sel), .conv_done(conv_done),
   .conv_result(conv_result), .amp_ctrl(amp_ctrl));
`default_nettype wire
